// *** config_entry_pkg.sv ***
// Constants and types shared by the configuration reset and serial entry logic.
// Assumes a 100 MHz system clock and a host-driven serial clock of its own.
package config_entry_pkg;

    // System clock rate in MHz.
    localparam int CLK_FREQ_MHZ = 100;

    // Extra wait after the serial port supply turns valid, in ns.
    localparam int POR_TIMEOUT_NS = 1000;
    // Least time, so the cycle count rounds up.
    localparam int POR_TIMEOUT_CYC = (POR_TIMEOUT_NS * CLK_FREQ_MHZ + 999) / 1000;
    // Width of the power-on timer.
    localparam int TMR_W = 8;

    // Shortest low pulse the host gives on the configuration reset, in ns.
    localparam int RESET_MIN_NS = 200;
    // Same figure in system clock cycles, rounded up.
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;

    // Positions of the watched supplies in the supply-good vector.
    localparam int SUPPLY_N = 4;
    localparam int SUP_CORE = 0;
    localparam int SUP_SPI = 1;
    localparam int SUP_BANK2 = 2;
    localparam int SUP_PROG = 3;

    // Positions of the control pins in their synchroniser vector.
    localparam int CTL_N = 3;
    localparam int CTL_RESET_N = 0;
    localparam int CTL_TEST_RST = 1;
    localparam int CTL_SEL_N = 2;

    // Word that opens an image on the serial link, and the image length after it.
    localparam int SYNC_W = 16;
    localparam logic [15:0] SYNC_WORD = 16'h7ea5;
    localparam int IMAGE_BITS = 64;
    localparam int CNT_W = 6;

    // Configuration sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_POR = 5'h01,
        ST_HOLD = 5'h02,
        ST_SPI_CFG = 5'h04,
        ST_OTHER = 5'h08,
        ST_DONE = 5'h10
    } cfg_state_t;

endpackage : config_entry_pkg

// *** sync2.sv ***
// Two flip-flop level synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; words must not be passed through it.
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // Clock, reset and enable of the receiving domain.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // The first stage feeds only the second stage.
    always_comb begin
        s_d = s_q;
        s_d.meta = d;
        s_d.stable = s_q.meta;
    end

    // Registers both stages; reset clears them to zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (en) begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stable;

endmodule : sync2

// *** config_entry.sv ***
// Power-on and pin reset control with entry into serial peripheral configuration.
// Assumes supply-good levels from analog monitors and a host driving the serial pins.
//
// Functional notes
// - Hold reset until all watched rails are good.
// - Extra timeout after serial supply becomes valid.
// - Watch core, serial, bank-2, programming supplies only.
// - Low configuration reset holds internal logic reset.
// - Test port command also resets internal logic.
// - Reset release with select low enters serial mode.
// - Select low at power-up enters serial mode.
// - Serial data output unused during peripheral configuration.
// - Done output shows configuration completion.
// - Serial pins become user I/O after done.
`timescale 1ns/1ps
module config_entry
    import config_entry_pkg::*;
(
    // System clock, synchronous active-low reset and clock enable.
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Supply-good levels from the power-on monitor comparators.
    input wire logic core_supply_ok,
    input wire logic spi_supply_ok,
    input wire logic bank2_io_supply_ok,
    input wire logic programming_supply_ok,
    // Reset pin from the host and reset request from the test port logic.
    input wire logic config_reset_n,
    input wire logic test_reset_req,
    // Serial link driven by the host processor.
    input wire logic spi_sck,
    input wire logic spi_si,
    input wire logic spi_ss_n,
    output logic spi_so,
    output logic spi_so_oe,
    // User logic drive for the serial output pin once configured.
    input wire logic user_so,
    input wire logic user_so_en,
    // Status towards the host and the rest of the device.
    output logic config_done,
    output logic spi_user_mode,
    output logic core_reset_n
);

    // State of the system clock domain.
    typedef struct packed {
        cfg_state_t st;
        logic [TMR_W-1:0] tmr;
        logic arm;
        logic rst_n;
        logic done;
        logic user;
        logic so;
        logic so_oe;
        logic empty_seen;
    } ctl_state_t;

    // State of the serial clock domain.
    typedef struct packed {
        logic [SYNC_W-1:0] shift;
        logic synced;
        logic [CNT_W-1:0] cnt;
        logic full;
    } link_state_t;

    localparam ctl_state_t CTL_RST = '{
        st: ST_POR, tmr: '0, arm: 1'b0, rst_n: 1'b0,
        done: 1'b0, user: 1'b0, so: 1'b0, so_oe: 1'b0, empty_seen: 1'b0
    };
    localparam logic [TMR_W-1:0] TMR_END = TMR_W'(POR_TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(IMAGE_BITS - 1);

    ctl_state_t c_q;
    ctl_state_t c_d;
    link_state_t k_q;
    link_state_t k_d;

    logic [SUPPLY_N-1:0] sup_raw;
    logic [SUPPLY_N-1:0] sup_s;
    logic [CTL_N-1:0] ctl_raw;
    logic [CTL_N-1:0] ctl_s;
    logic full_s;
    logic arm_k;
    logic sup_all;
    logic por_busy;
    logic ext_hold;
    logic hold;
    logic sel_low;
    logic [SYNC_W-1:0] shift_nx;

    // Only the four watched rails are gathered; the bank-1 rail has no input.
    always_comb begin
        sup_raw = '0;
        sup_raw[SUP_CORE] = core_supply_ok;
        sup_raw[SUP_SPI] = spi_supply_ok;
        sup_raw[SUP_BANK2] = bank2_io_supply_ok;
        sup_raw[SUP_PROG] = programming_supply_ok;
        ctl_raw = '0;
        ctl_raw[CTL_RESET_N] = config_reset_n;
        ctl_raw[CTL_TEST_RST] = test_reset_req;
        ctl_raw[CTL_SEL_N] = spi_ss_n;
    end

    // Supply monitor levels come from analog comparators and are synchronised.
    sync2 #(
        .W(SUPPLY_N)
    ) u_sup_sync (
        .clk(clk),
        .rst_n(nrst),
        .en(clk_en),
        .d(sup_raw),
        .q(sup_s)
    );

    // Host pins and the test port request are synchronised the same way.
    sync2 #(
        .W(CTL_N)
    ) u_ctl_sync (
        .clk(clk),
        .rst_n(nrst),
        .en(clk_en),
        .d(ctl_raw),
        .q(ctl_s)
    );

    // Image-complete level crosses from the serial domain.
    sync2 #(
        .W(1)
    ) u_full_sync (
        .clk(clk),
        .rst_n(nrst),
        .en(clk_en),
        .d(k_q.full),
        .q(full_s)
    );

    // Arm level crosses into the serial domain; it needs two serial edges to pass.
    sync2 #(
        .W(1)
    ) u_arm_sync (
        .clk(spi_sck),
        .rst_n(1'b1),
        .en(1'b1),
        .d(c_q.arm),
        .q(arm_k)
    );

    // Reset sources: supplies, the timeout, the reset pin and the test port.
    always_comb begin
        sup_all = &sup_s;
        por_busy = !sup_all || (c_q.tmr != TMR_END);
        ext_hold = !ctl_s[CTL_RESET_N] || ctl_s[CTL_TEST_RST];
        hold = por_busy || ext_hold;
        sel_low = !ctl_s[CTL_SEL_N];
    end

    // Sequencer: reset holds win, the select level is taken on release.
    always_comb begin
        c_d = c_q;
        // The timer restarts whenever the serial supply drops.
        if (!sup_s[SUP_SPI]) begin
            c_d.tmr = '0;
        end else if (c_q.tmr != TMR_END) begin
            c_d.tmr = c_q.tmr + TMR_W'(1);
        end
        if (por_busy) begin
            c_d.st = ST_POR;
        end else if (ext_hold) begin
            c_d.st = ST_HOLD;
        end else begin
            case (c_q.st)
                ST_POR: begin
                    // Leaving power-on reset; select low enters serial configuration, select high the other mode.
                    c_d.st = sel_low ? ST_SPI_CFG : ST_OTHER;
                end
                ST_HOLD: begin
                    // Leaving pin or test reset; select is sampled now.
                    c_d.st = sel_low ? ST_SPI_CFG : ST_OTHER;
                end
                ST_SPI_CFG: begin
                    // A full flag left over from an earlier image is not trusted until seen clear.
                    if (!full_s) begin
                        c_d.empty_seen = 1'b1;
                    end else if (c_q.empty_seen) begin
                        c_d.st = ST_DONE;
                    end
                end
                ST_OTHER: begin
                    c_d.st = ST_OTHER;
                end
                ST_DONE: begin
                    c_d.st = ST_DONE;
                end
                default: begin
                    c_d.st = ST_POR;
                end
            endcase
        end
        // The clear-seen mark lives only while serial configuration runs.
        if (c_d.st != ST_SPI_CFG) begin
            c_d.empty_seen = 1'b0;
        end
        c_d.rst_n = !hold;
        c_d.arm = (c_d.st == ST_SPI_CFG);
        c_d.done = (c_d.st == ST_DONE);
        c_d.user = (c_d.st == ST_DONE);
        // The serial output stays undriven until user logic owns the pin.
        if (c_d.st == ST_DONE) begin
            c_d.so = user_so;
            c_d.so_oe = user_so_en;
        end else begin
            c_d.so = 1'b0;
            c_d.so_oe = 1'b0;
        end
    end

    // System domain registers, frozen while the clock enable is low.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            c_q <= CTL_RST;
        end else if (clk_en) begin
            c_q <= c_d;
        end
    end

    // Serial receiver: hunt for the sync word, then count image bits.
    always_comb begin
        k_d = k_q;
        shift_nx = {k_q.shift[SYNC_W-2:0], spi_si};
        if (!arm_k || spi_ss_n) begin
            // Edges outside configuration or with select high clear the receiver.
            // This also flushes the unknown power-up state, as the link has no reset.
            k_d = '0;
        end else if (!k_q.full) begin
            if (!k_q.synced) begin
                k_d.shift = shift_nx;
                k_d.synced = (shift_nx == SYNC_WORD);
            end else begin
                k_d.shift = shift_nx;
                k_d.cnt = k_q.cnt + CNT_W'(1);
                k_d.full = (k_q.cnt == CNT_LAST);
            end
        end
    end

    // Serial domain registers on the host clock.
    always_ff @(posedge spi_sck) begin
        k_q <= k_d;
    end

    // Outputs straight from registers.
    assign config_done = c_q.done;
    assign spi_user_mode = c_q.user;
    assign core_reset_n = c_q.rst_n;
    assign spi_so = c_q.so;
    assign spi_so_oe = c_q.so_oe;

endmodule : config_entry

// *** config_entry_checker.sv ***
// Checker bound to config_entry: reset causes, power-on wait, pin hand-over.
// Assumes clk_en is held high.
`timescale 1ns/1ps
module config_entry_checker
    import config_entry_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Reset causes.
    input wire logic core_supply_ok,
    input wire logic spi_supply_ok,
    input wire logic bank2_io_supply_ok,
    input wire logic programming_supply_ok,
    input wire logic config_reset_n,
    input wire logic test_reset_req,
    // User drive and outputs.
    input wire logic user_so,
    input wire logic user_so_en,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic config_done,
    input wire logic spi_user_mode,
    input wire logic core_reset_n
);
    logic [TMR_W-1:0] up_q;
    logic all_ok;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // All watched rails good together.
    assign all_ok = core_supply_ok && spi_supply_ok && bank2_io_supply_ok && programming_supply_ok;
    // Counts cycles of steady serial supply, saturating.
    always_ff @(posedge clk) begin
        if (!nrst || !spi_supply_ok) begin
            up_q <= '0;
        end else if (up_q != '1) begin
            up_q <= up_q + 1'h1;
        end
    end
    property p_rails; (!all_ok)[*4] |-> !core_reset_n; endproperty
    a_rails: assert property (p_rails) else $error("rail down, core free");
    property p_por; $rose(core_reset_n) |-> up_q >= POR_TIMEOUT_CYC; endproperty
    a_por: assert property (p_por) else $error("core freed early");
    property p_pin; (!config_reset_n)[*4] |-> !core_reset_n && !config_done; endproperty
    a_pin: assert property (p_pin) else $error("pin reset ignored");
    property p_test; $rose(test_reset_req) |-> ##3 !core_reset_n; endproperty
    a_test: assert property (p_test) else $error("test reset ignored");
    property p_pair; config_done |-> spi_user_mode && core_reset_n; endproperty
    a_pair: assert property (p_pair) else $error("done without release");
    property p_mode; $rose(spi_user_mode) |-> $rose(config_done); endproperty
    a_mode: assert property (p_mode) else $error("pins freed early");
    property p_quiet; !config_done ##1 !config_done |-> !spi_so && !spi_so_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("output driven early");
    property p_user;
        config_done ##1 config_done |-> spi_so == $past(user_so) && spi_so_oe == $past(user_so_en);
    endproperty
    a_user: assert property (p_user) else $error("user drive lost");
    c_done: cover property ($rose(config_done));
    c_test: cover property ($rose(test_reset_req) ##3 !core_reset_n);
    c_por: cover property ($rose(core_reset_n));
endmodule : config_entry_checker

bind config_entry config_entry_checker chk (.clk(clk), .nrst(nrst),
    .core_supply_ok(core_supply_ok), .spi_supply_ok(spi_supply_ok),
    .bank2_io_supply_ok(bank2_io_supply_ok), .programming_supply_ok(programming_supply_ok),
    .config_reset_n(config_reset_n), .test_reset_req(test_reset_req), .user_so(user_so),
    .user_so_en(user_so_en), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .config_done(config_done), .spi_user_mode(spi_user_mode), .core_reset_n(core_reset_n));

// *** host_model.sv ***
// Host processor model driving the configuration reset and serial pins.
// Assumes the bench calls its tasks; the 80 ns serial clock stops between frames.
`timescale 1ns/1ps
module host_model
    import config_entry_pkg::*;
(
    // Pins towards the device.
    output logic config_reset_n,
    output logic spi_sck,
    output logic spi_si,
    output logic spi_ss_n
);
    // Idle pins; a pull-down holds select low at power-up.
    initial begin
        config_reset_n = 1'h1;
        spi_sck = 1'h0;
        spi_si = 1'h0;
        spi_ss_n = 1'h0;
    end
    // Drops the reset with select set, holds it, then lets it rise.
    task automatic pulse_reset(input int low_ns, input logic sel);
        spi_ss_n = sel;
        config_reset_n = 1'h0;
        #(low_ns);
        config_reset_n = 1'h1;
        #100;
        spi_ss_n = 1'h1;
    endtask : pulse_reset
    // Two dummy clocks, then the image MSB first with select low.
    task automatic send(input logic [SYNC_W+IMAGE_BITS-1:0] v);
        #7;
        for (int i = SYNC_W + IMAGE_BITS + 1; i >= 0; i--) begin
            spi_ss_n = (i >= SYNC_W + IMAGE_BITS);
            spi_si = spi_ss_n ? ~spi_si : v[i];
            #40 spi_sck = 1'h1;
            #40 spi_sck = 1'h0;
        end
        spi_ss_n = 1'h1;
        spi_si = ~spi_si; // A released line must not keep its last bit.
    endtask : send
endmodule : host_model

// *** config_entry_tb.sv ***
// Testbench for config_entry: power-up, pin, test and rail resets, image load.
// Assumes host_model drives the link and the checker is bound to uut.
`timescale 1ns/1ps
module config_entry_tb
    import config_entry_pkg::*;
;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [SUPPLY_N-1:0] sup = '0;
    logic test_reset_req = 1'h0;
    logic user_so = 1'h0;
    logic user_so_en = 1'h0;
    logic config_reset_n, spi_sck, spi_si, spi_ss_n;
    logic spi_so, spi_so_oe, config_done, spi_user_mode, core_reset_n;
    int seed = 43642;
    int n_errors = 0;
    int total_checks = 0;
    // Free-running system clock.
    always #5 clk = ~clk;
    // Device and host.
    config_entry uut (.clk(clk), .nrst(nrst), .clk_en(1'h1),
        .core_supply_ok(sup[SUP_CORE]), .spi_supply_ok(sup[SUP_SPI]),
        .bank2_io_supply_ok(sup[SUP_BANK2]), .programming_supply_ok(sup[SUP_PROG]),
        .config_reset_n(config_reset_n), .test_reset_req(test_reset_req), .spi_sck(spi_sck),
        .spi_si(spi_si), .spi_ss_n(spi_ss_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
        .user_so(user_so), .user_so_en(user_so_en), .config_done(config_done),
        .spi_user_mode(spi_user_mode), .core_reset_n(core_reset_n));
    host_model host (.config_reset_n(config_reset_n), .spi_sck(spi_sck), .spi_si(spi_si),
        .spi_ss_n(spi_ss_n));
    // Counts a comparison and reports a mismatch.
    task automatic check(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %b, expected %b", $time, got, exp);
        end
    endtask : check
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // Waits n rising edges, then steps just past the edge.
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    // Done is expected only when select was low at release.
    function automatic logic exp_done(input logic sel);
        return !sel;
    endfunction : exp_done
    // Sync word followed by random image bits.
    function automatic logic [SYNC_W+IMAGE_BITS-1:0] image();
        return {SYNC_WORD, $random(seed), $random(seed)};
    endfunction : image
    // Loads an image once the core is free, then checks the outcome.
    task automatic load(input logic sel);
        for (int i = 0; i < 400 && core_reset_n !== 1'h1; i++) cycles(1);
        host.send(image());
        cycles(8);
        check(config_done, exp_done(sel));
        check(spi_user_mode, exp_done(sel));
    endtask : load
    // Main sequence.
    initial begin
        cycles(8);
        nrst = 1'h1;
        repeat (12) begin
            check(core_reset_n, 1'h0);
            sup[$unsigned($random(seed)) % SUPPLY_N] = 1'h1;
            sup[SUP_SPI] = 1'h0;
            cycles(20);
        end
        sup = '1;
        cycles(POR_TIMEOUT_CYC);
        check(core_reset_n, 1'h0);
        cycles(10);
        check(core_reset_n, 1'h1);
        load(1'h0);
        repeat (6) begin
            {user_so, user_so_en} = 2'($random(seed));
            cycles(2);
            check(spi_so, user_so);
            check(spi_so_oe, user_so_en);
        end
        for (int s = 1; s >= 0; s--) begin
            host.pulse_reset(200 + 10 * ($unsigned($random(seed)) % 10), s[0]);
            check(config_done, 1'h0);
            load(s[0]);
        end
        test_reset_req = 1'h1;
        cycles(4);
        check(core_reset_n, 1'h0);
        check(config_done, 1'h0);
        test_reset_req = 1'h0;
        cycles(6);
        check(core_reset_n, 1'h1);
        for (int k = 0; k < SUPPLY_N; k++) begin
            sup[k] = 1'h0;
            cycles(4);
            check(core_reset_n, 1'h0);
            sup[k] = 1'h1;
            cycles(POR_TIMEOUT_CYC + 8);
            check(core_reset_n, 1'h1);
        end
        stop_test();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #300000;
        n_errors++;
        stop_test();
    end
endmodule : config_entry_tb
